// [rtl/pisf_event_flags.sv]
// sticky event status flags, their enables, the interrupt control register and the shared pin
`timescale 1ns/1ns
// Contract
// - a source's pending flag sets whenever its event occurred since the last status read
// - with its enable set, a pending source raises the interrupt
// - the interrupt also needs the control register to allow it
// - flags set on events regardless of their enable bits
// - bit 15 holds link quality pending, resets 0, read-only, clears on read
// - bit 14 holds energy detect pending, resets 0, clears on read
// - bit 13 holds link status change pending, resets 0, clears on read
// - bit 12 is speed change, or speed-or-duplex change when remapped; clears on read
// - without remap, bit 11 holds duplex change pending, clears on read
// - with remap, bit 11 is time event; rearms only once time status is empty
// - bit 10 holds autonegotiation done pending, resets 0, clears on read
// - frame mode zero: bit 9 is false carrier counter half-full, clears on read
// - frame mode nonzero: bit 9 is either counter half-full, clears on read
// - event interrupts reach the pin only while global enable is 1
// - output enable 1 makes the shared pin the interrupt; 0 keeps power-down input
// - remap select picks the bit 11 and bit 12 source mappings
module pisf_event_flags #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic clk,
	input wire logic sys_rst,
	// management pins, both asynchronous to clk
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	// event pulses, one clock wide, from the same clock
	input wire logic link_quality_event,
	input wire logic energy_detect_event,
	input wire logic link_change_event,
	input wire logic speed_change_event,
	input wire logic duplex_change_event,
	input wire logic time_event,
	input wire logic autoneg_done_event,
	input wire logic false_carrier_halffull_event,
	input wire logic rx_error_halffull_event,
	// levels from neighbouring registers
	input wire logic time_status_empty,
	input wire logic [1:0] frame_mode,
	// shared pin, active low both ways; the input is asynchronous
	input wire logic powerdown_or_irq_pin_in,
	output logic powerdown_or_irq_pin_out,
	output logic powerdown_or_irq_pin_oe,
	output logic powerdown_req
);
	import pisf_pkg::*;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// one compare shared by the read clear and both write paths
	function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a,
		input logic [ADDR_WIDTH-1:0] t);
		addr_hit = (a == t);
	endfunction

	// ----------------------------------------------------------------
	// management access
	// ----------------------------------------------------------------
	logic [ADDR_WIDTH-1:0] reg_addr;
	logic rd_strobe, wr_strobe;
	logic [REG_WIDTH-1:0] rd_data, wr_data;

	pisf_mdio_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_mdio (
		.clk(clk),
		.sys_rst(sys_rst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.reg_addr(reg_addr),
		.rd_strobe(rd_strobe),
		.rd_data(rd_data),
		.wr_strobe(wr_strobe),
		.wr_data(wr_data)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] pending, next_pending;
	logic [NUM_SRC-1:0] enable, next_enable;
	logic [CTL_WIDTH-1:0] ctl, next_ctl;
	logic time_armed, next_time_armed;
	logic pin_s1, pin_s2;
	logic pin_out, next_pin_out;
	logic pd_req, next_pd_req;
	// mapped sources and the decoded interrupt terms
	logic [NUM_SRC-1:0] src;
	logic remap, clear_now, irq, event_irq, test_irq;
	logic hit_status, hit_control;

	assign remap = ctl[CTL_REMAP];

	// event sources as mapped by remap select and frame mode
	always_comb begin
		src = '0;
		src[SRC_LINK_QUALITY] = link_quality_event;
		src[SRC_ENERGY] = energy_detect_event;
		src[SRC_LINK] = link_change_event;
		src[SRC_SPEED] = remap ? (speed_change_event | duplex_change_event) : speed_change_event;
		// time events only count while armed, so a burst yields one flag
		src[SRC_DUPLEX_OR_TIME] = remap ? (time_event & time_armed) : duplex_change_event;
		src[SRC_AUTONEG] = autoneg_done_event;
		if (frame_mode == FRAME_MODE_PLAIN) begin
			src[SRC_COUNTER] = false_carrier_halffull_event;
		end else begin
			src[SRC_COUNTER] = false_carrier_halffull_event | rx_error_halffull_event;
		end
	end

	// read data mux; reserved bits and unmapped addresses read as zero
	always_comb begin
		rd_data = '0;
		case (reg_addr)
			ADDR_EVENT_STATUS: begin
				rd_data[FLAG_LSB +: NUM_SRC] = pending;
				rd_data[ENABLE_LSB +: NUM_SRC] = enable;
			end
			ADDR_INT_CONTROL: begin
				rd_data[CTL_WIDTH-1:0] = ctl;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// register selects; the read mux keeps its own case on the same address
	assign hit_status = addr_hit(reg_addr, ADDR_EVENT_STATUS);
	assign hit_control = addr_hit(reg_addr, ADDR_INT_CONTROL);
	assign clear_now = rd_strobe && hit_status;

	// ----------------------------------------------------------------
	// flags, enables and control
	// ----------------------------------------------------------------
	// clear drops only what this read returned, and a same-cycle event still sets
	always_comb begin
		next_pending = (clear_now ? FLAG_RESET : pending) | src;
		next_enable = enable;
		next_ctl = ctl;
		if (wr_strobe && hit_status) begin
			next_enable = wr_data[ENABLE_LSB +: NUM_SRC]; // flag bits of the word are dropped
		end
		if (wr_strobe && hit_control) begin
			next_ctl = wr_data[CTL_WIDTH-1:0];
		end
	end

	// flag, enable and control registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pending <= FLAG_RESET;
			enable <= ENABLE_RESET;
			ctl <= CTL_RESET;
		end else begin
			pending <= next_pending;
			enable <= next_enable;
			ctl <= next_ctl;
		end
	end

	// ----------------------------------------------------------------
	// time event arming
	// ----------------------------------------------------------------
	// disarm on the event that flags, rearm once the status queue drains
	// a host that never drains the status queue never sees a second time flag
	always_comb begin
		if (time_armed) begin
			next_time_armed = ~(remap & time_event);
		end else begin
			next_time_armed = time_status_empty;
		end
	end

	// arm register; armed out of reset so the first time event with remap set always flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			time_armed <= 1'b1;
		end else begin
			time_armed <= next_time_armed;
		end
	end

	// ----------------------------------------------------------------
	// shared power-down / interrupt pin
	// ----------------------------------------------------------------
	// event path: any enabled pending flag, and only while globally enabled
	assign event_irq = ctl[CTL_GLOBAL_EN] & (|(pending & enable));
	// test interrupt bypasses the event gating, but still needs the output enabled
	assign test_irq = ctl[CTL_TEST_INT];
	assign irq = event_irq | test_irq;

	// pin is active low in both directions
	always_comb begin
		next_pin_out = ~(irq & ctl[CTL_OUTPUT_EN]);
		next_pd_req = ~ctl[CTL_OUTPUT_EN] & ~pin_s2;
	end

	// pin synchroniser and registered pin outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			pin_out <= 1'b1;
			pd_req <= 1'b0;
		end else begin
			pin_s1 <= powerdown_or_irq_pin_in;
			pin_s2 <= pin_s1;
			pin_out <= next_pin_out;
			pd_req <= next_pd_req;
		end
	end

	assign powerdown_or_irq_pin_out = pin_out;
	assign powerdown_or_irq_pin_oe = ctl[CTL_OUTPUT_EN];
	assign powerdown_req = pd_req;
endmodule

// [rtl/pisf_mdio_slave.sv]
// serial management frame slave: samples the management clock and moves register words
`timescale 1ns/1ns
module pisf_mdio_slave #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	output logic [pisf_pkg::ADDR_WIDTH-1:0] reg_addr,
	output logic rd_strobe,
	input wire logic [pisf_pkg::REG_WIDTH-1:0] rd_data,
	output logic wr_strobe,
	output logic [pisf_pkg::REG_WIDTH-1:0] wr_data
);
	import pisf_pkg::*;

	// header decode shared by the read and write paths; a foreign phy address never matches
	function automatic logic hdr_is(input logic [HDR_BITS-1:0] h, input logic [1:0] op);
		hdr_is = (h[HDR_BITS-1 -: 2] == op) && (h[ADDR_WIDTH +: ADDR_WIDTH] == PHY_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
	logic rise, bit_in;

	// two stages per pin; third mdc stage only feeds the edge finder
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mdc_s1 <= 1'b0;
			mdc_s2 <= 1'b0;
			mdc_s3 <= 1'b0;
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
		end else begin
			mdc_s1 <= mdc;
			mdc_s2 <= mdc_s1;
			mdc_s3 <= mdc_s2;
			mdio_s1 <= mdio_in;
			mdio_s2 <= mdio_s1;
		end
	end

	assign rise = mdc_s2 & ~mdc_s3;
	assign bit_in = mdio_s2;

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	pisf_mdio_state_t state, next_state;
	logic [5:0] cnt, next_cnt;
	logic [HDR_BITS-1:0] hdr, next_hdr;
	logic [REG_WIDTH-1:0] sh, next_sh;
	logic is_rd, next_is_rd, is_wr, next_is_wr;
	logic out, next_out, oe, next_oe, wr_pend, next_wr_pend;

	// one step per rising management clock; host samples on that edge, so we drive after it
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_hdr = hdr;
		next_sh = sh;
		next_is_rd = is_rd;
		next_is_wr = is_wr;
		next_out = out;
		next_oe = oe;
		next_wr_pend = 1'b0;
		rd_strobe = 1'b0;
		if (rise) begin
			case (state)
				MS_PREAMBLE: begin
					if (bit_in) begin
						if (cnt != PREAMBLE_ONES) next_cnt = cnt + 6'h01;
					end else begin
						if (cnt == PREAMBLE_ONES) next_state = MS_START;
						next_cnt = 6'h00;
					end
				end
				MS_START: begin
					next_state = bit_in ? MS_HEADER : MS_PREAMBLE;
					next_cnt = 6'h00;
				end
				MS_HEADER: begin
					next_hdr = {hdr[HDR_BITS-2:0], bit_in};
					next_cnt = cnt + 6'h01;
					if (cnt == HDR_LAST) begin
						next_is_rd = hdr_is(next_hdr, OP_READ);
						next_is_wr = hdr_is(next_hdr, OP_WRITE);
						next_state = MS_TURN1;
					end
				end
				MS_TURN1: begin
					// word is snapshotted here, the same cycle its read-clear happens
					if (is_rd) begin
						rd_strobe = 1'b1;
						next_sh = rd_data;
						next_oe = 1'b1;
						next_out = 1'b0;
					end
					next_state = MS_TURN2;
				end
				MS_TURN2: begin
					if (is_rd) begin
						next_out = sh[REG_WIDTH-1];
						next_sh = {sh[REG_WIDTH-2:0], 1'b0};
					end
					next_cnt = 6'h00;
					next_state = MS_DATA;
				end
				MS_DATA: begin
					next_cnt = cnt + 6'h01;
					if (is_rd) begin
						next_out = sh[REG_WIDTH-1];
						next_sh = {sh[REG_WIDTH-2:0], 1'b0};
					end else begin
						next_sh = {sh[REG_WIDTH-2:0], bit_in};
					end
					if (cnt == DATA_LAST) begin
						next_oe = 1'b0;
						next_out = 1'b0;
						next_wr_pend = is_wr;
						next_cnt = 6'h00;
						next_state = MS_PREAMBLE;
					end
				end
				default: begin
					next_state = MS_PREAMBLE;
					next_cnt = 6'h00;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= MS_PREAMBLE;
			cnt <= 6'h00;
			hdr <= '0;
			sh <= '0;
			is_rd <= 1'b0;
			is_wr <= 1'b0;
			out <= 1'b0;
			oe <= 1'b0;
			wr_pend <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			hdr <= next_hdr;
			sh <= next_sh;
			is_rd <= next_is_rd;
			is_wr <= next_is_wr;
			out <= next_out;
			oe <= next_oe;
			wr_pend <= next_wr_pend;
		end
	end

	assign mdio_out = out;
	assign mdio_oe = oe;
	assign reg_addr = hdr[ADDR_WIDTH-1:0];
	assign wr_strobe = wr_pend;
	assign wr_data = sh;
endmodule

// [rtl/pisf_pkg.sv]
// constants and types shared by the event status flag block and its management slave
package pisf_pkg;
	// ----------------------------------------------------------------
	// register map on the management bus
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_INT_CONTROL = 5'h11;
	localparam logic [4:0] ADDR_EVENT_STATUS = 5'h12;
	localparam int REG_WIDTH = 16;
	localparam int ADDR_WIDTH = 5;

	// ----------------------------------------------------------------
	// event sources, index into pending and enable vectors
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 7;
	localparam int SRC_COUNTER = 0;
	localparam int SRC_AUTONEG = 1;
	localparam int SRC_DUPLEX_OR_TIME = 2;
	localparam int SRC_SPEED = 3;
	localparam int SRC_LINK = 4;
	localparam int SRC_ENERGY = 5;
	localparam int SRC_LINK_QUALITY = 6;
	localparam int FLAG_LSB = 9;
	localparam int ENABLE_LSB = 1;
	localparam logic [NUM_SRC-1:0] FLAG_RESET = 7'h00;
	localparam logic [NUM_SRC-1:0] ENABLE_RESET = 7'h00;

	// ----------------------------------------------------------------
	// interrupt control register fields
	// ----------------------------------------------------------------
	localparam int CTL_WIDTH = 4;
	localparam int CTL_OUTPUT_EN = 0;
	localparam int CTL_GLOBAL_EN = 1;
	localparam int CTL_TEST_INT = 2;
	localparam int CTL_REMAP = 3;
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 4'h0;
	localparam logic [1:0] FRAME_MODE_PLAIN = 2'h0;

	// ----------------------------------------------------------------
	// management frame layout
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0b;
	localparam logic [5:0] DATA_LAST = 6'h0f;
	localparam int HDR_BITS = 12;

	typedef enum {
		MS_PREAMBLE,
		MS_START,
		MS_HEADER,
		MS_TURN1,
		MS_TURN2,
		MS_DATA
	} pisf_mdio_state_t;
endpackage

// [verification/pisf_event_flags_bench.sv]
// self-checking bench for the event flag block
`timescale 1ns/1ns
module pisf_event_flags_bench;
	import pisf_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mdc, h_en, h_bit, mdio_out, mdio_oe, pin_out, pin_oe, pd_req;
	logic [8:0] ev = 9'h000;
	logic [1:0] fm = 2'h0;
	logic empty = 1'b1;
	logic pd_drv = 1'b1;
	logic [15:0] seen_val;
	logic [15:0] exp_q[$];
	event seen;
	int fails = 0;
	int check_count = 0;
	// pulled-up data line and shared pin, resolved from every driver
	wire logic mdio_in = mdio_oe ? mdio_out : (h_en ? h_bit : 1'b1);
	wire logic pin_in = pin_oe ? pin_out : pd_drv;
	always #5 clk = ~clk;
	pisf_mdio_host pisf_mdio_host_inst (.mdc, .drv_en(h_en), .drv_bit(h_bit), .mdio(mdio_in));
	pisf_event_flags pisf_event_flags_inst (.clk, .sys_rst, .mdc, .mdio_in, .mdio_out,
		.mdio_oe, .link_quality_event(ev[0]), .energy_detect_event(ev[1]),
		.link_change_event(ev[2]), .speed_change_event(ev[3]), .duplex_change_event(ev[4]),
		.time_event(ev[5]), .autoneg_done_event(ev[6]), .false_carrier_halffull_event(ev[7]),
		.rx_error_halffull_event(ev[8]), .time_status_empty(empty), .frame_mode(fm),
		.powerdown_or_irq_pin_in(pin_in), .powerdown_or_irq_pin_out(pin_out),
		.powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(pd_req));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// oldest note against each result as it shows up
	always @(seen) check(seen_val, exp_q.pop_front());
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] r;
		exp_q.push_back(e);
		pisf_mdio_host_inst.xfer(OP_READ, a, 16'h0000, r);
		seen_val = r;
		->seen;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] r;
		pisf_mdio_host_inst.xfer(OP_WRITE, a, d, r);
	endtask
	// settled pin view: sel 0 irq level, sel 1 power-down request
	task automatic pin(input logic sel, input logic e);
		repeat (4) @(posedge clk);
		#2 exp_q.push_back({15'h0000, e});
		seen_val = {15'h0000, sel ? pd_req : pin_out};
		->seen;
	endtask
	// pin direction as set by the output enable bit
	task automatic dir(input logic e);
		#1 exp_q.push_back({15'h0000, e});
		seen_val = {15'h0000, pin_oe};
		->seen;
	endtask
	task automatic pulse(input logic [8:0] v, input logic [1:0] f);
		@(posedge clk);
		#1 ev = v;
		fm = f;
		@(posedge clk);
		#1 ev = 9'h000;
	endtask
	function automatic logic [15:0] flags(input logic [8:0] v, input logic rm,
		input logic [1:0] f);
		flags = {v[0], v[1], v[2], v[3] | (rm & v[4]), rm ? v[5] : v[4], v[6],
			v[7] | ((f != 2'h0) & v[8]), 9'h000};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [8:0] v;
		logic [1:0] f;
		logic [15:0] e;
		v = 9'($urandom(32'ha93ef420));
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd(ADDR_EVENT_STATUS, 16'h0000);
		rd(ADDR_INT_CONTROL, 16'h0000);
		rd(5'h05, 16'h0000);
		wr(ADDR_EVENT_STATUS, 16'hffff);
		// random sources under both bit maps and all frame modes
		for (int i = 0; i < 12; i++) begin
			v = 9'($urandom);
			f = 2'($urandom);
			wr(ADDR_INT_CONTROL, {12'h000, i[0], 3'h0});
			pulse(v, f);
			e = flags(v, i[0], f) | 16'h00fe;
			rd(ADDR_EVENT_STATUS, e);
			rd(ADDR_EVENT_STATUS, 16'h00fe);
		end
		// status still queued keeps the time flag disarmed
		wr(ADDR_INT_CONTROL, 16'h0008);
		@(posedge clk);
		#1 empty = 1'b0;
		pulse(9'h020, 2'h0);
		pulse(9'h020, 2'h0);
		rd(ADDR_EVENT_STATUS, 16'h08fe);
		pulse(9'h020, 2'h0);
		rd(ADDR_EVENT_STATUS, 16'h00fe);
		@(posedge clk);
		#1 empty = 1'b1;
		pulse(9'h020, 2'h0);
		rd(ADDR_EVENT_STATUS, 16'h08fe);
		// a held event straddles the clearing read, so the flag outlives it
		@(posedge clk);
		#1 ev = 9'h004;
		rd(ADDR_EVENT_STATUS, 16'h20fe);
		@(posedge clk);
		#1 ev = 9'h000;
		rd(ADDR_EVENT_STATUS, 16'h20fe);
		rd(ADDR_EVENT_STATUS, 16'h00fe);
		// shared pin: global gate, source enable, forced interrupt
		wr(ADDR_EVENT_STATUS, 16'h0080);
		wr(ADDR_INT_CONTROL, 16'h0001);
		pulse(9'h001, 2'h0);
		pin(1'b0, 1'b1);
		dir(1'b1);
		wr(ADDR_INT_CONTROL, 16'h0003);
		pin(1'b0, 1'b0);
		rd(ADDR_EVENT_STATUS, 16'h8080);
		pin(1'b0, 1'b1);
		pulse(9'h002, 2'h0);
		pin(1'b0, 1'b1);
		wr(ADDR_INT_CONTROL, 16'hfff4);
		pin(1'b0, 1'b1);
		rd(ADDR_INT_CONTROL, 16'h0004);
		wr(ADDR_INT_CONTROL, 16'h0005);
		pin(1'b0, 1'b0);
		rd(ADDR_EVENT_STATUS, 16'h4080);
		// pin as power-down input, then back to output mode
		wr(ADDR_INT_CONTROL, 16'h0000);
		@(posedge clk);
		#1 pd_drv = 1'b0;
		pin(1'b1, 1'b1);
		dir(1'b0);
		wr(ADDR_INT_CONTROL, 16'h0001);
		pin(1'b1, 1'b0);
		results;
	end
	// hang guard: about sixty frames of 5.12 us each, so 600 us is twice the expected run
	initial begin
		#600000;
		fails++;
		results;
	end
endmodule

// [verification/pisf_event_flags_chk.sv]
// pin-level checks on the event flag block
`timescale 1ns/1ns
module pisf_event_flags_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic powerdown_or_irq_pin_in,
	input wire logic powerdown_or_irq_pin_out,
	input wire logic powerdown_or_irq_pin_oe,
	input wire logic powerdown_req
);
	logic [7:0] oe_cnt;
	logic [7:0] next_oe_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// drive window length, saturating so a stuck enable cannot wrap
	always_comb begin
		next_oe_cnt = (mdio_oe && oe_cnt != 8'hff) ? oe_cnt + 8'h01 : (mdio_oe ? oe_cnt : 8'h00);
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			oe_cnt <= 8'h00;
		end else begin
			oe_cnt <= next_oe_cnt;
		end
	end
	sequence s_pin_high;
		powerdown_or_irq_pin_in [*5];
	endsequence
	sequence s_pin_low_in;
		(!powerdown_or_irq_pin_in && !powerdown_or_irq_pin_oe) [*5];
	endsequence
	sequence s_read_drive;
		!mdio_out ##1 mdio_oe [*7];
	endsequence
	AST_LEAVE_RST: assert property ($fell(sys_rst) |-> powerdown_or_irq_pin_out
		&& !powerdown_or_irq_pin_oe && !mdio_oe) else $error("outputs not idle at reset exit");
	AST_PIN_IDLE_OFF: assert property (!$past(powerdown_or_irq_pin_oe) |->
		powerdown_or_irq_pin_out) else $error("irq asserted while pin is an input");
	AST_PD_NOT_OE: assert property (powerdown_req |->
		!$past(powerdown_or_irq_pin_oe)) else $error("power-down asked in output mode");
	AST_PD_HIGH: assert property (s_pin_high |-> !powerdown_req)
		else $error("power-down with pin high");
	AST_PD_LOW: assert property (s_pin_low_in |-> powerdown_req)
		else $error("power-down missed");
	AST_READ_TA: assert property ($rose(mdio_oe) |-> s_read_drive)
		else $error("read drive window broken");
	AST_READ_LEN: assert property ($fell(mdio_oe) |-> $past(oe_cnt) > 8'h84)
		else $error("read word cut short");
	AST_READ_MAX: assert property (oe_cnt < 8'h8c)
		else $error("data line driven too long");
endmodule
bind pisf_event_flags pisf_event_flags_chk pisf_event_flags_chk_inst (.clk, .sys_rst,
	.mdio_out, .mdio_oe, .powerdown_or_irq_pin_in, .powerdown_or_irq_pin_out,
	.powerdown_or_irq_pin_oe, .powerdown_req);

// [verification/pisf_mdio_host.sv]
// management host model that clocks frames into the flag block
`timescale 1ns/1ns
module pisf_mdio_host (
	output logic mdc,
	output logic drv_en,
	output logic drv_bit,
	input wire logic mdio
);
	// mdc rests low between frames; data moves on the falling edge
	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_bit = 1'b1;
	end
	// one 80 ns slot; the line is taken at the rising edge
	task automatic slot(input logic b, input logic en, output logic s);
		drv_en = en;
		drv_bit = b;
		#40 mdc = 1'b1;
		s = mdio;
		#40 mdc = 1'b0;
	endtask
	// full frame; a read lets go of the line from the turnaround on
	task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		logic own;
		hdr = {32'hffffffff, 2'b01, op, 5'h01, ra};
		own = (op != pisf_pkg::OP_READ);
		for (int i = 45; i >= 0; i--) slot(hdr[i], 1'b1, s);
		slot(1'b1, own, s);
		slot(1'b0, own, s);
		for (int i = 15; i >= 0; i--) begin
			slot(wd[i], own, s);
			rd[i] = s;
		end
		drv_en = 1'b0;
	endtask
endmodule
